// ===== hdl/oie_pkg.sv
// Purpose: Shared constants and types for the opto input expander target.
// Assumes: One 250 MHz clock, synchronous active high reset.
// Notes: Bus lines, jumpers and inputs all arrive from outside this clock domain.
`default_nettype none

package oie_pkg;

    // Bus line pair as seen at the pins
    typedef struct packed {
        logic scl;
        logic sda;
    } oie_i2c_type;

    // Address jumpers
    typedef struct packed {
        logic addr_jumper_bit2;
        logic addr_jumper_bit1;
        logic addr_jumper_bit0;
    } oie_jumper_type;

    // Target protocol states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,  // Waiting for a start
        ST_ADDR = 3'b001,  // Shifting in the address byte
        ST_AACK = 3'b010,  // Driving the address acknowledge
        ST_DATA = 3'b011,  // Shifting out the input byte
        ST_DACK = 3'b100   // Sampling the controller acknowledge
    } oie_state_type;

    localparam int CHANNELS = 8;               // Input channels
    localparam int JUMPERS = 3;                // Jumper bits
    localparam int SYNC_W = 2 + JUMPERS + 1 + CHANNELS; // Synchronised bits
    localparam logic [3:0] UPPER_VARIANT0 = 4'h2; // Upper address, variant 0
    localparam logic [3:0] UPPER_VARIANT1 = 4'h3; // Upper address, variant 1
    localparam logic [3:0] BIT_COUNT_ZERO = 4'h0; // Bit counter start
    localparam logic [3:0] BIT_COUNT_ONE = 4'h1;  // Bit counter step
    localparam logic [3:0] ADDR_BITS_DONE = 4'h8; // Address byte complete
    localparam logic [3:0] DATA_LAST_BIT = 4'h7;  // Last data bit driven
    localparam logic [7:0] LAST_READ_RESET = 8'h00; // Input byte seen at reset
    // Synchroniser reset: bus lines sit at their idle high level, so no false edge
    // follows reset; jumpers, strap and inputs clear to zero
    localparam logic [SYNC_W-1:0] SYNC_RESET = 14'h3000;

endpackage : oie_pkg

`default_nettype wire

// ===== hdl/oie_sync.sv
// Purpose: Two flip-flop synchroniser for a vector of asynchronous pins.
// Assumes: Each bit is independent; no multi-bit coherence is needed.
// Notes: The first stage is read only by the second stage.
`default_nettype none

module oie_sync
    import oie_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [oie_pkg::SYNC_W-1:0] async_i,
    output logic [oie_pkg::SYNC_W-1:0] sync_o
);

    logic [SYNC_W-1:0] stage1; // Metastability catcher
    logic [SYNC_W-1:0] stage2; // Settled copy

    // One pair of flops per bit
    for (genvar b = 0; b < SYNC_W; b++) begin : g_bit
        always_ff @(posedge clock_i) begin
            if (rst_i) begin
                stage1[b] <= SYNC_RESET[b];
                stage2[b] <= SYNC_RESET[b];
            end else begin
                stage1[b] <= async_i[b];
                stage2[b] <= stage1[b];
            end
        end
    end

    assign sync_o = stage2;

endmodule : oie_sync

`default_nettype wire

// ===== hdl/oie_expander.sv
// Purpose: Read-only eight input bus target with open drain interrupt.
// Assumes: Bus clock far slower than clock_i; pins settle between edges.
// Notes: Input byte is sampled when it is loaded for shifting out.
`default_nettype none

module oie_expander (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire oie_pkg::oie_i2c_type bus_i,
    input wire oie_pkg::oie_jumper_type jumper_i,
    input wire logic variant_i,
    input wire logic [oie_pkg::CHANNELS-1:0] isolated_input_i,
    output logic sda_out_o,
    output logic sda_oe_o,
    output logic int_out_o,
    output logic int_oe_o
);
    import oie_pkg::*;

    logic [SYNC_W-1:0] pins_s;        // Synchronised pin vector
    oie_i2c_type bus_s;               // Synchronised bus lines
    oie_jumper_type jumper_s;         // Synchronised jumpers
    logic variant_s;                  // Synchronised variant strap
    logic [CHANNELS-1:0] port_bit;    // Synchronised inputs, bit 0 is input one

    oie_state_type state;             // Protocol state
    oie_state_type next_state;
    logic [7:0] shift;                // Address in or data out
    logic [7:0] next_shift;
    logic [3:0] bit_cnt;              // Bits moved in this byte
    logic [3:0] next_bit_cnt;
    logic master_ack;                 // Controller asked for another byte
    logic next_master_ack;
    logic [7:0] last_read;            // Byte last handed to the controller
    logic [7:0] next_last_read;
    logic scl_prev;                   // Last bus clock level
    logic sda_prev;                   // Last bus data level
    logic next_sda_oe;
    logic next_int_oe;
    logic load;                       // Input byte taken this cycle

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [6:0] own_addr;             // Full seven bit target address

    // Every pin passes two flops before use
    oie_sync u_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i({bus_i, jumper_i, variant_i, isolated_input_i}),
        .sync_o(pins_s)
    );

    assign {bus_s, jumper_s, variant_s, port_bit} = pins_s;

    // Bus edge and condition detection
    assign scl_rise = bus_s.scl && !scl_prev;
    assign scl_fall = !bus_s.scl && scl_prev;
    assign start_seen = bus_s.scl && scl_prev && sda_prev && !bus_s.sda;
    assign stop_seen = bus_s.scl && scl_prev && !sda_prev && bus_s.sda;

    // Address: fixed variant bits above the jumper bits
    assign own_addr = {variant_s ? UPPER_VARIANT1 : UPPER_VARIANT0, jumper_s};

    // Next state of the target
    always_comb begin
        next_state = state;
        next_shift = shift;
        next_bit_cnt = bit_cnt;
        next_master_ack = master_ack;
        next_last_read = last_read;
        load = 1'b0;
        if (start_seen) begin
            // Start or repeated start begins a new address byte
            next_state = ST_ADDR;
            next_bit_cnt = BIT_COUNT_ZERO;
        end else if (stop_seen) begin
            // Stop ends any transfer
            next_state = ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    next_bit_cnt = BIT_COUNT_ZERO;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        // Sample address bits, most significant first
                        next_shift = {shift[6:0], bus_s.sda};
                        next_bit_cnt = bit_cnt + BIT_COUNT_ONE;
                    end else if (scl_fall && bit_cnt == ADDR_BITS_DONE) begin
                        // Acknowledge only our own address
                        if (shift[7:1] == own_addr) begin
                            next_state = ST_AACK;
                        end else begin
                            next_state = ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        if (shift[0]) begin
                            load = 1'b1;
                        end else begin
                            // Writes carry nothing for an input board
                            next_state = ST_IDLE;
                        end
                    end
                end
                ST_DATA: begin
                    if (scl_fall) begin
                        if (bit_cnt == DATA_LAST_BIT) begin
                            // Release data line for the controller acknowledge
                            next_state = ST_DACK;
                            next_master_ack = 1'b0;
                        end else begin
                            next_shift = {shift[6:0], 1'b0};
                            next_bit_cnt = bit_cnt + BIT_COUNT_ONE;
                        end
                    end
                end
                ST_DACK: begin
                    if (scl_rise) begin
                        if (bus_s.sda) begin
                            // Not acknowledged: transfer over
                            next_state = ST_IDLE;
                        end else begin
                            next_master_ack = 1'b1;
                        end
                    end else if (scl_fall && master_ack) begin
                        load = 1'b1;
                    end
                end
            endcase
        end
        if (load) begin
            // Fresh sample of the inputs, input one in bit zero
            next_state = ST_DATA;
            next_shift = port_bit;
            next_bit_cnt = BIT_COUNT_ZERO;
            next_last_read = port_bit;
        end
        // Drive low for acknowledge or a zero data bit
        next_sda_oe = !((next_state == ST_AACK) ||
                        (next_state == ST_DATA && !next_shift[7]));
        // Pull interrupt while inputs differ from what was last read
        next_int_oe = (port_bit == next_last_read);
    end

    // Register all state and outputs
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            shift <= LAST_READ_RESET;
            bit_cnt <= BIT_COUNT_ZERO;
            master_ack <= 1'b0;
            last_read <= LAST_READ_RESET;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
            sda_oe_o <= 1'b1;
            sda_out_o <= 1'b0;
            int_oe_o <= 1'b1;
            int_out_o <= 1'b0;
        end else begin
            state <= next_state;
            shift <= next_shift;
            bit_cnt <= next_bit_cnt;
            master_ack <= next_master_ack;
            last_read <= next_last_read;
            scl_prev <= bus_s.scl;
            sda_prev <= bus_s.sda;
            sda_oe_o <= next_sda_oe;
            sda_out_o <= 1'b0;
            int_oe_o <= next_int_oe;
            int_out_o <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // Controller acknowledge was latched, then the clock fell
    sequence s_master_ack;
        state == ST_DACK && master_ack ##0 scl_fall;
    endsequence

    // Controller declined
    sequence s_master_nack;
        state == ST_DACK && scl_rise && bus_s.sda;
    endsequence

    addr_match_a: assert property (
        $rose(state == ST_AACK) |-> $past(shift[7:1]) == own_addr
    ) else $error("acknowledged a foreign address");

    variant_upper_a: assert property (
        state == ST_AACK |-> shift[7:4] == (variant_s ? UPPER_VARIANT1 : UPPER_VARIANT0)
    ) else $error("upper address bits do not match variant");

    ack_drive_a: assert property (
        state == ST_AACK |-> !sda_oe_o
    ) else $error("address acknowledge not driven");

    bit_order_a: assert property (
        load |=> shift == $past(port_bit) && last_read == $past(port_bit)
    ) else $error("input byte loaded out of order");

    next_byte_a: assert property (
        s_master_ack |=> state == ST_DATA
    ) else $error("acknowledged byte not followed by data");

    nack_idle_a: assert property (
        (s_master_nack and (!start_seen && !stop_seen)) |=> state == ST_IDLE
    ) else $error("no release after controller decline");

    int_assert_a: assert property (
        port_bit != last_read && !load |=> !int_oe_o
    ) else $error("input change did not pull interrupt");

    int_release_a: assert property (
        (port_bit == last_read) [*2] |-> int_oe_o
    ) else $error("interrupt held with inputs matching last read");

    open_drain_a: assert property (
        !int_out_o && !sda_out_o
    ) else $error("open drain line driven high");

    data_release_a: assert property (
        state == ST_DACK |-> sda_oe_o
    ) else $error("data line held during controller acknowledge");

endmodule : oie_expander

`default_nettype wire

// ===== tb/oie_host.sv
// Purpose: Bus controller model that reads the expander over the two wire bus.
// Assumes: The data line has a pull-up, so a released line reads high.
// Notes: One bus bit takes four phases of HALF_CLKS system clocks.
`default_nettype none

module oie_host #(
    parameter int HALF_CLKS = 625 // Default keeps the bus clock at 100 kHz
) (
    input wire logic clock_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Both lines released while the bus is idle
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // Waits one phase, then moves off the clock edge
    task automatic wait_phase();
        repeat (HALF_CLKS) @(posedge clock_i);
        #1;
    endtask : wait_phase

    // Data changes only in the middle of the low phase
    task automatic put_bit(input logic b);
        wait_phase();
        sda_o = b;
        wait_phase();
        scl_o = 1'b1;
        wait_phase();
        wait_phase();
        scl_o = 1'b0;
    endtask : put_bit

    // Releases the data line and samples it late in the high phase
    task automatic get_bit(output logic b);
        wait_phase();
        sda_o = 1'b1;
        wait_phase();
        scl_o = 1'b1;
        wait_phase();
        wait_phase();
        b = sda_i;
        scl_o = 1'b0;
    endtask : get_bit

    // Start, address byte, then data bytes acked but the last
    task automatic frame(input logic [7:0] abyte, input int nbytes,
                         output logic ack, output logic [15:0] data);
        logic b;
        data = 16'h0000;
        wait_phase();
        sda_o = 1'b0;
        wait_phase();
        scl_o = 1'b0;
        for (int i = 7; i >= 0; i--) put_bit(abyte[i]);
        get_bit(b);
        ack = !b;
        if (ack && abyte[0]) begin
            for (int k = 0; k < nbytes; k++) begin
                for (int i = 0; i < 8; i++) begin
                    get_bit(b);
                    data = {data[14:0], b};
                end
                put_bit(k == nbytes - 1);
            end
        end
        wait_phase();
        sda_o = 1'b0;
        wait_phase();
        scl_o = 1'b1;
        wait_phase();
        sda_o = 1'b1;
        wait_phase();
    endtask : frame

endmodule : oie_host

`default_nettype wire

// ===== tb/oie_expander_test.sv
// Purpose: Self-checking bench for the opto input expander target.
// Assumes: One board on the bus; pull-ups on data and interrupt lines.
// Notes: Bus phases are shortened to keep the run brief.
`default_nettype none

module oie_expander_test;
    timeunit 1ns;
    timeprecision 1ns;
    import oie_pkg::*;

    logic clock_i; // System clock
    logic rst_i; // Synchronous reset
    logic variant_i; // Variant strap
    oie_jumper_type jumper; // Address jumpers
    logic [7:0] inputs; // Isolated inputs
    logic sda_out, sda_oe, int_out, int_oe, scl_h, sda_h;
    wire logic sda_line; // Resolved data line
    wire logic int_line; // Resolved interrupt line
    int errors;
    int samples_checked;
    logic ack;
    logic [15:0] data;

    assign sda_line = sda_h & (sda_oe | sda_out);
    assign int_line = int_oe | int_out;

    oie_expander uut (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .bus_i({scl_h, sda_line}),
        .jumper_i(jumper),
        .variant_i(variant_i),
        .isolated_input_i(inputs),
        .sda_out_o(sda_out),
        .sda_oe_o(sda_oe),
        .int_out_o(int_out),
        .int_oe_o(int_oe)
    );

    oie_host #(.HALF_CLKS(10)) host (
        .clock_i(clock_i),
        .sda_i(sda_line),
        .scl_o(scl_h),
        .sda_o(sda_h)
    );

    // Clock generator
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    // Reports and stops the run
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    // Compares one bit
    task automatic check_bit(input string name, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask : check_bit

    // Compares a data word
    task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check_word

    // Waits a bounded time for the interrupt line to reach a level
    task automatic wait_int(input logic exp);
        // Looks off the edge so the registered output has settled
        for (int i = 0; i < 8 && int_line !== exp; i++) begin
            @(posedge clock_i);
            #1;
        end
        check_bit("int line", exp, int_line);
    endtask : wait_int

    // Every jumper setting of both variants; foreign address refused
    task automatic t_address();
        logic [3:0] up;
        logic [7:0] pat;
        for (int v = 0; v < 2; v++) begin
            for (int j = 0; j < 8; j++) begin
                up = v ? UPPER_VARIANT1 : UPPER_VARIANT0;
                pat = v ? ~(8'h01 << j) : (8'h01 << j);
                variant_i = v[0];
                jumper = j[2:0];
                inputs = pat;
                host.frame({up, j[2:0], 1'b1}, 1, ack, data);
                check_bit("ack", 1'b1, ack);
                check_word("data", {8'h00, pat}, data);
                check_bit("int after read", 1'b1, int_line);
                host.frame({up ^ 4'h1, j[2:0], 1'b1}, 1, ack, data);
                check_bit("foreign ack", 1'b0, ack);
            end
        end
    endtask : t_address

    // Change raises interrupt, return drops it, poll by read clears it
    task automatic t_interrupt();
        logic [7:0] cur;
        cur = inputs;
        inputs = cur ^ 8'h80;
        wait_int(1'b0);
        check_bit("int out", 1'b0, int_out);
        inputs = cur;
        wait_int(1'b1);
        inputs = 8'hA5;
        wait_int(1'b0);
        host.frame({UPPER_VARIANT1, jumper, 1'b1}, 2, ack, data);
        check_word("two bytes", 16'hA5A5, data);
        check_bit("int cleared", 1'b1, int_line);
    endtask : t_interrupt

    // Write direction acked, then a read still works
    task automatic t_write();
        host.frame({UPPER_VARIANT1, jumper, 1'b0}, 1, ack, data);
        check_bit("write ack", 1'b1, ack);
        inputs = 8'h3C;
        host.frame({UPPER_VARIANT1, jumper, 1'b1}, 1, ack, data);
        check_word("after write", 16'h003C, data);
    endtask : t_write

    // Reset in mid-run releases the interrupt, then unread inputs pull it again
    task automatic t_reset();
        inputs = 8'hC3;
        wait_int(1'b0);
        rst_i = 1'b1;
        repeat (8) @(posedge clock_i);
        #1;
        check_bit("int in reset", 1'b1, int_line);
        check_bit("sda in reset", 1'b1, sda_line);
        rst_i = 1'b0;
        @(posedge clock_i);
        #1;
        check_bit("int after reset", 1'b1, int_line);
        wait_int(1'b0);
        host.frame({UPPER_VARIANT1, jumper, 1'b1}, 1, ack, data);
        check_word("after reset", 16'h00C3, data);
        check_bit("int reread", 1'b1, int_line);
    endtask : t_reset

    // Main sequence
    initial begin
        errors = 0;
        samples_checked = 0;
        rst_i = 1'b1;
        variant_i = 1'b0;
        jumper = 3'h0;
        inputs = 8'h00;
        repeat (8) @(posedge clock_i);
        #1;
        rst_i = 1'b0;
        repeat (4) @(posedge clock_i);
        #1;
        check_bit("int idle", 1'b1, int_line);
        t_address();
        t_interrupt();
        t_write();
        t_reset();
        end_sim();
    end

    // Watchdog: the tests need about 22400 cycles, so 60000 is a hang
    initial begin
        repeat (60000) @(posedge clock_i);
        errors++;
        end_sim();
    end

endmodule : oie_expander_test

`default_nettype wire
